// ==== shared/dual_timer_pkg.sv ====
// constants and carrier types for the dual 8-bit interval and square-wave timer
// How it works
// - in cascade, run_enable_a alone runs both
// - level set/reset trigger bits read zero
// - match interval is compare plus one ticks
// - cascade count clock from select bits 3:0
// - cascade compare low byte A, high B
// - mode 02h gives two counters, B running
// - mode 07h gives cascade, both stages on
// - wave output inverts on timer A compare match when toggle_a is set and no level trigger is written that cycle
// - output control 03h toggles pin on A match
// - timer B match raises interrupt, vector 26h
// - mask clear passes interrupt, set blocks it
// - bypass bit makes prescaler run at oscillator
// - clock select resets 00h; codes 2-5 prohibited
package dual_timer_pkg;

   // ---------------------------------------------------------------
   // register images
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [4:0] unused;
      logic cascade;       // one 16-bit counter when set
      logic run_enable_b;
      logic run_enable_a;
   } mode_ctrl_type;

   typedef struct packed {
      logic level_set_b;
      logic level_reset_b;
      logic toggle_b;
      logic out_enable_b;
      logic level_set_a;
      logic level_reset_a;
      logic toggle_a;
      logic wave_out_enable;
   } wave_ctrl_type;

   typedef struct packed {
      logic [3:0] sel_b;
      logic [3:0] sel_a;
   } clk_sel_type;

   // ---------------------------------------------------------------
   // reset values and fixed figures
   // ---------------------------------------------------------------
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] WAVE_CTRL_RESET = 8'h00;
   localparam logic [7:0] CLK_SEL_RESET = 8'h00;
   localparam logic [7:0] TRIGGER_MASK = 8'h33;   // keeps all but the four trigger bits
   localparam logic [7:0] IRQ_VECTOR_B = 8'h26;
   localparam logic [3:0] SEL_EXT_FALL = 4'h0;
   localparam logic [3:0] SEL_EXT_RISE = 4'h1;
   localparam logic [3:0] SEL_FIRST_INT = 4'h6;
   localparam logic [3:0] SEL_SLOWEST = 4'hF;
   localparam logic [3:0] SEL_INT_OFFSET = 4'h5;  // code 6 divides by 2^1
   localparam logic [3:0] SEL_SLOWEST_EXP = 4'hB; // code 15 divides by 2^11
   localparam int PRESCALE_WIDTH = 11;

endpackage

// ==== rtl/dual_timer.sv ====
// dual 8-bit interval timer, cascadable to 16 bits, with square-wave pin and timer B interrupt
module dual_timer (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic mode_wr,
   input wire logic [7:0] mode_wdata,
   input wire logic clk_sel_wr,
   input wire logic [7:0] clk_sel_wdata,
   input wire logic wave_ctrl_wr,
   input wire logic [7:0] wave_ctrl_wdata,
   input wire logic [7:0] compare_a,
   input wire logic [7:0] compare_b,
   input wire logic divider_bypass,
   input wire logic match_irq_mask_b,
   input wire logic event_in_a,
   input wire logic event_in_b,
   output logic [7:0] timer_mode_ctrl,
   output logic [7:0] count_clock_select,
   output logic [7:0] wave_output_ctrl,
   output logic [7:0] count_a,
   output logic [7:0] count_b,
   output logic match_a,
   output logic match_b,
   output logic match_irq_b,
   output logic [7:0] irq_vector_b,
   output logic wave_out_pin
);

   // ---------------------------------------------------------------
   // synchronisers for the two event pins
   // ---------------------------------------------------------------
   logic [1:0] sync1_reg, sync1_next;
   logic [1:0] sync2_reg, sync2_next;
   logic [1:0] sync3_reg, sync3_next;

   // first stage feeds only the second stage; edges are taken from stages two and three
   always_comb begin
      sync1_next = {event_in_b, event_in_a};
      sync2_next = sync1_reg;
      sync3_next = sync2_reg;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= 2'h0;
         sync2_reg <= 2'h0;
         sync3_reg <= 2'h0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         sync3_reg <= sync3_next;
      end
   end

   logic [1:0] ext_rise, ext_fall;
   assign ext_rise = sync2_reg & ~sync3_reg;
   assign ext_fall = ~sync2_reg & sync3_reg;

   // ---------------------------------------------------------------
   // count clock selection
   // ---------------------------------------------------------------
   function automatic logic sel_tick(input logic [3:0] code, input logic [10:0] pre,
                                     input logic fx_en, input logic rise, input logic fall);
      logic [3:0] exp_v;
      logic [10:0] mask_v;
      exp_v = (code == dual_timer_pkg::SEL_SLOWEST) ? dual_timer_pkg::SEL_SLOWEST_EXP
                                                    : 4'(code - dual_timer_pkg::SEL_INT_OFFSET);
      mask_v = 11'((12'h001 << exp_v) - 12'h001);
      if (code == dual_timer_pkg::SEL_EXT_FALL) sel_tick = fall;
      else if (code == dual_timer_pkg::SEL_EXT_RISE) sel_tick = rise;
      else if (code < dual_timer_pkg::SEL_FIRST_INT) sel_tick = 1'b0; // prohibited codes never tick
      else sel_tick = fx_en && ((pre & mask_v) == mask_v);
   endfunction

   // ---------------------------------------------------------------
   // control registers, prescaler, counters and outputs
   // ---------------------------------------------------------------
   dual_timer_pkg::mode_ctrl_type mode_reg, mode_next;
   dual_timer_pkg::clk_sel_type sel_reg, sel_next;
   dual_timer_pkg::wave_ctrl_type wave_ctrl_reg, wave_ctrl_next;
   logic [10:0] pre_reg, pre_next;
   logic half_reg, half_next;
   logic [7:0] cnt_a_reg, cnt_a_next, cnt_b_reg, cnt_b_next;
   logic match_a_reg, match_a_next, match_b_reg, match_b_next;
   logic irq_reg, irq_next;
   logic wave_reg, wave_next;
   logic pin_reg, pin_next;
   logic [7:0] vector_reg;
   logic fx_en, tick_a, tick_b, evt_a, evt_b;
   dual_timer_pkg::wave_ctrl_type wr_img;

   always_comb begin
      // clock divider by two unless bypassed
      fx_en = divider_bypass || half_reg;
      half_next = ~half_reg;
      pre_next = fx_en ? 11'(pre_reg + 11'h001) : pre_reg;
      tick_a = sel_tick(sel_reg.sel_a, pre_reg, fx_en, ext_rise[0], ext_fall[0]);
      tick_b = sel_tick(sel_reg.sel_b, pre_reg, fx_en, ext_rise[1], ext_fall[1]);
      mode_next = mode_wr ? dual_timer_pkg::mode_ctrl_type'(mode_wdata) : mode_reg;
      sel_next = clk_sel_wr ? dual_timer_pkg::clk_sel_type'(clk_sel_wdata) : sel_reg;
      wr_img = dual_timer_pkg::wave_ctrl_type'(wave_ctrl_wdata);
      // trigger bits act once and are never stored, so they read back as zero
      wave_ctrl_next = wave_ctrl_wr ? dual_timer_pkg::wave_ctrl_type'(wave_ctrl_wdata & dual_timer_pkg::TRIGGER_MASK)
                                    : wave_ctrl_reg;
      cnt_a_next = cnt_a_reg;
      cnt_b_next = cnt_b_reg;
      evt_a = 1'b0;
      evt_b = 1'b0;
      if (mode_reg.cascade) begin
         // run_enable_a and clock field A govern the combined counter
         if (!mode_reg.run_enable_a) begin
            cnt_a_next = 8'h00;
            cnt_b_next = 8'h00;
         end else if (tick_a) begin
            if ({cnt_b_reg, cnt_a_reg} == {compare_b, compare_a}) begin
               cnt_a_next = 8'h00;
               cnt_b_next = 8'h00;
               evt_a = 1'b1;
               evt_b = 1'b1;
            end else begin
               {cnt_b_next, cnt_a_next} = 16'({cnt_b_reg, cnt_a_reg} + 16'h0001);
            end
         end
      end else begin
         if (!mode_reg.run_enable_a) cnt_a_next = 8'h00;
         else if (tick_a) begin
            evt_a = (cnt_a_reg == compare_a);
            cnt_a_next = evt_a ? 8'h00 : 8'(cnt_a_reg + 8'h01);
         end
         if (!mode_reg.run_enable_b) cnt_b_next = 8'h00;
         else if (tick_b) begin
            evt_b = (cnt_b_reg == compare_b);
            cnt_b_next = evt_b ? 8'h00 : 8'(cnt_b_reg + 8'h01);
         end
      end
      match_a_next = evt_a;
      match_b_next = evt_b;
      irq_next = evt_b && !match_irq_mask_b;
      // a level trigger wins over a toggle in the same cycle
      wave_next = wave_reg;
      if (wave_ctrl_wr && wr_img.level_set_a) wave_next = 1'b1;
      else if (wave_ctrl_wr && wr_img.level_reset_a) wave_next = 1'b0;
      else if (evt_a && wave_ctrl_reg.toggle_a) wave_next = ~wave_reg;
      pin_next = wave_ctrl_reg.wave_out_enable && wave_next;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode_reg <= dual_timer_pkg::mode_ctrl_type'(dual_timer_pkg::MODE_RESET);
         sel_reg <= dual_timer_pkg::clk_sel_type'(dual_timer_pkg::CLK_SEL_RESET);
         wave_ctrl_reg <= dual_timer_pkg::wave_ctrl_type'(dual_timer_pkg::WAVE_CTRL_RESET);
         pre_reg <= 11'h000;
         half_reg <= 1'b0;
         cnt_a_reg <= 8'h00;
         cnt_b_reg <= 8'h00;
         match_a_reg <= 1'b0;
         match_b_reg <= 1'b0;
         irq_reg <= 1'b0;
         wave_reg <= 1'b0;
         pin_reg <= 1'b0;
         vector_reg <= dual_timer_pkg::IRQ_VECTOR_B;
      end else begin
         mode_reg <= mode_next;
         sel_reg <= sel_next;
         wave_ctrl_reg <= wave_ctrl_next;
         pre_reg <= pre_next;
         half_reg <= half_next;
         cnt_a_reg <= cnt_a_next;
         cnt_b_reg <= cnt_b_next;
         match_a_reg <= match_a_next;
         match_b_reg <= match_b_next;
         irq_reg <= irq_next;
         wave_reg <= wave_next;
         pin_reg <= pin_next;
         vector_reg <= vector_reg;
      end
   end

   // outputs straight from flip-flops
   assign timer_mode_ctrl = mode_reg;
   assign count_clock_select = sel_reg;
   assign wave_output_ctrl = wave_ctrl_reg;
   assign count_a = cnt_a_reg;
   assign count_b = cnt_b_reg;
   assign match_a = match_a_reg;
   assign match_b = match_b_reg;
   assign match_irq_b = irq_reg;
   assign irq_vector_b = vector_reg;
   assign wave_out_pin = pin_reg;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_trig_read_zero;
      @(posedge core_clk) disable iff (rst)
      wave_ctrl_wr |=> (wave_output_ctrl & ~dual_timer_pkg::TRIGGER_MASK) == 8'h00;
   endproperty
   a_trig_read_zero: assert property (p_trig_read_zero) else $error("trigger bits read nonzero");

   property p_match_clear;
      @(posedge core_clk) disable iff (rst)
      (!mode_reg.cascade && mode_reg.run_enable_a && tick_a && cnt_a_reg == compare_a)
      |=> (count_a == 8'h00) && match_a;
   endproperty
   a_match_clear: assert property (p_match_clear) else $error("counter A did not clear on match");

   property p_count_up;
      @(posedge core_clk) disable iff (rst)
      (mode_reg.run_enable_a && !mode_wr && tick_a && {cnt_b_reg, cnt_a_reg} != {compare_b, compare_a}
       && mode_reg.cascade) |=> {count_b, count_a} == 16'($past({cnt_b_reg, cnt_a_reg}) + 16'h0001);
   endproperty
   a_count_up: assert property (p_count_up) else $error("cascade counter failed to step");

   property p_stop_zero;
      @(posedge core_clk) disable iff (rst)
      !mode_reg.run_enable_a ##1 !mode_reg.run_enable_a |-> count_a == 8'h00;
   endproperty
   a_stop_zero: assert property (p_stop_zero) else $error("stopped counter not zero");

   property p_irq_pass;
      @(posedge core_clk) disable iff (rst)
      evt_b |=> match_irq_b == !$past(match_irq_mask_b);
   endproperty
   a_irq_pass: assert property (p_irq_pass) else $error("interrupt masking wrong");

   property p_irq_cause;
      @(posedge core_clk) disable iff (rst)
      match_irq_b |-> match_b;
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("interrupt without B match");

   property p_toggle;
      @(posedge core_clk) disable iff (rst)
      (evt_a && wave_ctrl_reg.toggle_a && !wave_ctrl_wr) |=> wave_reg != $past(wave_reg);
   endproperty
   a_toggle: assert property (p_toggle) else $error("wave did not invert on match");

   property p_cascade_cmp;
      @(posedge core_clk) disable iff (rst)
      (mode_reg.cascade && match_a_next) |-> {cnt_b_reg, cnt_a_reg} == {compare_b, compare_a};
   endproperty
   a_cascade_cmp: assert property (p_cascade_cmp) else $error("cascade matched wrong value");

   property p_sel_reset;
      @(posedge core_clk) disable iff (rst)
      $past(rst) |-> count_clock_select == dual_timer_pkg::CLK_SEL_RESET;
   endproperty
   a_sel_reset: assert property (p_sel_reset) else $error("clock select not cleared by reset");

   property p_mode_two;
      @(posedge core_clk) disable iff (rst)
      (mode_wr && mode_wdata == 8'h02) |=> !mode_reg.cascade && mode_reg.run_enable_b && !mode_reg.run_enable_a;
   endproperty
   a_mode_two: assert property (p_mode_two) else $error("mode 02h decoded wrong");

   property p_pin_silent;
      @(posedge core_clk) disable iff (rst)
      !wave_ctrl_reg.wave_out_enable |=> !wave_out_pin;
   endproperty
   a_pin_silent: assert property (p_pin_silent) else $error("pin driven while disabled");

   property p_bypass;
      @(posedge core_clk) disable iff (rst)
      divider_bypass |-> fx_en;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass did not bypass divider");

   c_cascade_match: cover property (@(posedge core_clk) disable iff (rst) mode_reg.cascade && evt_a);
   c_irq_b: cover property (@(posedge core_clk) disable iff (rst) match_irq_b);
   c_pin_toggle: cover property (@(posedge core_clk) disable iff (rst) $rose(wave_out_pin));

endmodule // dual_timer

// ==== test/event_source.sv ====
// event source model standing on the two timer input pins
module event_source (
   input wire logic core_clk,
   input wire logic fire_a,
   input wire logic fire_b,
   output logic event_in_a,
   output logic event_in_b
);
   timeunit 1ns;
   timeprecision 1ns;

   // the source always drives its pins, so they idle low rather than float
   initial begin
      event_in_a = 1'h0;
      event_in_b = 1'h0;
   end

   // one pulse per request; the 7 ns offset keeps pin edges apart from core_clk edges
   always begin
      @(posedge core_clk iff fire_a);
      #7 event_in_a = 1'h1;
      repeat (5) @(posedge core_clk);
      #7 event_in_a = 1'h0;
   end

   // same for pin b; five cycles high lets the synchroniser see both edges
   always begin
      @(posedge core_clk iff fire_b);
      #7 event_in_b = 1'h1;
      repeat (5) @(posedge core_clk);
      #7 event_in_b = 1'h0;
   end
endmodule // event_source

// ==== test/tb_top.sv ====
// self-checking bench for the dual interval and square-wave timer
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'h0;
   logic rst = 1'h1;
   logic mode_wr = 1'h0, clk_sel_wr = 1'h0, wave_ctrl_wr = 1'h0, fire_a = 1'h0, fire_b = 1'h0;
   logic [7:0] mode_wdata = 8'h00, clk_sel_wdata = 8'h00, wave_ctrl_wdata = 8'h00;
   logic [7:0] compare_a = 8'h00, compare_b = 8'h00;
   logic divider_bypass = 1'h1, match_irq_mask_b = 1'h0;
   logic event_in_a, event_in_b, match_a, match_b, match_irq_b, wave_out_pin, prev;
   logic [7:0] timer_mode_ctrl, count_clock_select, wave_output_ctrl, count_a, count_b, irq_vector_b;
   int error_cnt = 0, n_tests = 0, m_cnt = 0, i_cnt = 0, m0, i0, n, c, code;

   always #25 core_clk = ~core_clk;

   dual_timer dut_u (.core_clk, .rst, .mode_wr, .mode_wdata, .clk_sel_wr, .clk_sel_wdata, .wave_ctrl_wr,
      .wave_ctrl_wdata, .compare_a, .compare_b, .divider_bypass, .match_irq_mask_b, .event_in_a, .event_in_b,
      .timer_mode_ctrl, .count_clock_select, .wave_output_ctrl, .count_a, .count_b, .match_a, .match_b,
      .match_irq_b, .irq_vector_b, .wave_out_pin);
   event_source src_u (.core_clk, .fire_a, .fire_b, .event_in_a, .event_in_b);

   // pulse tallies; sampled before the edge's updates land, so each pulse counts once
   always @(posedge core_clk) begin
      m_cnt += (match_b === 1'h1);
      i_cnt += (match_irq_b === 1'h1);
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // one-cycle write strobe, then the readback is compared one cycle later
   task automatic wr(input int r, input logic [7:0] d);
      @(posedge core_clk);
      if (r == 0) {mode_wr, mode_wdata} <= {1'h1, d};
      else if (r == 1) {clk_sel_wr, clk_sel_wdata} <= {1'h1, d};
      else {wave_ctrl_wr, wave_ctrl_wdata} <= {1'h1, d};
      @(posedge core_clk);
      {mode_wr, clk_sel_wr, wave_ctrl_wr} <= 3'h0;
      #1;
      if (r == 0) check("mode", timer_mode_ctrl, d);
      else if (r == 1) check("clk_sel", count_clock_select, d);
      else check("wave_ctrl", wave_output_ctrl, d & 8'h33);
   endtask

   // cycles up to the next match pulse, bounded so a dead counter cannot hang the run
   task automatic wait_match(input bit b, output int k);
      k = 0;
      do begin
         @(posedge core_clk);
         #1;
         k++;
      end while ((b ? match_b : match_a) !== 1'h1 && k < 5000);
   endtask

   task automatic idle(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask

   // (compare + 1) ticks; code 15 skips 2^10, and without bypass the prescaler runs at half rate
   function automatic int exp_gap(input int cmp, input int cd, input bit byp);
      int t;
      t = (cd == 15) ? 2048 : (1 << (cd - 5));
      return (cmp + 1) * t * (byp ? 1 : 2);
   endfunction

   // watchdog: the whole sequence needs far fewer cycles than this
   initial begin
      repeat (60000) @(posedge core_clk);
      error_cnt++;
      finish_test();
   end

   initial begin
      void'($urandom(32'hC9B6));
      repeat (12) @(posedge core_clk);
      rst <= 1'h0;
      idle(1);
      check("vector", irq_vector_b, 8'h26);
      check("clk_sel reset", count_clock_select, 8'h00);
      $display("test reset done");
      // timer b alone: random compare, clock code and divider, mask alternating
      for (int i = 0; i < 4; i++) begin
         code = $urandom_range(8, 6);
         c = (i == 0) ? 0 : $urandom_range(12, 1);
         @(posedge core_clk);
         divider_bypass <= (i == 1) ? 1'h0 : 1'($urandom_range(1, 0));
         match_irq_mask_b <= i[0];
         compare_b <= c[7:0];
         wr(1, {code[3:0], 4'h2});
         wr(0, 8'h02);
         wait_match(1, n);
         m0 = m_cnt;
         i0 = i_cnt;
         wait_match(1, n);
         check("gap b", n, exp_gap(c, code, divider_bypass));
         wr(0, 8'h00);
         idle(4);
         check("irq", i_cnt - i0, i[0] ? 0 : m_cnt - m0);
         check("stop b", count_b, 8'h00);
      end
      $display("test timer b done");
      // cascade: b clock field holds a prohibited code, which must not matter
      @(posedge core_clk);
      divider_bypass <= 1'h1;
      compare_a <= 8'($urandom_range(15, 0));
      compare_b <= 8'h01;
      wr(1, 8'h26);
      for (int j = 0; j < 2; j++) begin
         // halt before every mode change, even one that only flips run_enable_b
         wr(0, 8'h00);
         wr(0, j ? 8'h05 : 8'h07);
         wait_match(0, n);
         wait_match(0, n);
         check("gap cascade", n, exp_gap({compare_b, compare_a}, 6, 1'h1));
      end
      wr(0, 8'h06);
      idle(20);
      check("cascade held", {count_b, count_a}, 16'h0000);
      $display("test cascade done");
      // square wave on pin a, with forced levels first while stopped
      c = $urandom_range(6, 2);
      @(posedge core_clk);
      compare_a <= c[7:0];
      wr(2, 8'h0B);
      idle(3);
      check("level set", wave_out_pin, 1'h1);
      wr(2, 8'h07);
      idle(3);
      check("level reset", wave_out_pin, 1'h0);
      wr(2, 8'h03);
      wr(0, 8'h01);
      for (int j = 0; j < 4; j++) begin
         prev = wave_out_pin;
         wait_match(0, n);
         check("wave", wave_out_pin, 1'(~prev));
         if (j > 0) check("gap a", n, exp_gap(c, 6, 1'h1));
      end
      wr(0, 8'h00);
      wr(2, 8'h02);
      idle(3);
      check("silenced", wave_out_pin, 1'h0);
      $display("test wave done");
      // external edges: a counts falling edges, b rising edges
      @(posedge core_clk);
      compare_a <= 8'hFF;
      compare_b <= 8'hFF;
      wr(1, 8'h10);
      wr(0, 8'h03);
      for (int k = 1; k < 4; k++) begin
         @(posedge core_clk);
         {fire_a, fire_b} <= 2'h3;
         @(posedge core_clk);
         {fire_a, fire_b} <= 2'h0;
         idle(16);
         check("edges a", count_a, 8'(k));
         check("edges b", count_b, 8'(k));
      end
      wr(0, 8'h00);
      idle(2);
      check("stop ab", {count_b, count_a}, 16'h0000);
      $display("test events done");
      finish_test();
   end
endmodule // tb_top
